// >>> hdl/flash_reset_control.sv
// Reset detection, software reset and power-mode control of a serial NOR flash device
//
// Overview of operation
// - Signalling reset is recognised from select, data line zero and a still clock.
// - Internal reset fires only when the fourth pulse ends with select high.
// - Signalling reset aborts work, floats outputs, ignores transactions, then standby.
// - Signalling detector works in every state; effect equals a reset-pin reset.
// - Software reset reloads volatile config but keeps boot and protection registers.
// - Software reset starts when select rises and lasts the software reset time.
// - Any other transaction after arm disarms; later reset command then ignored.
// - During software reset accept only status-one and read-any-register reads, and only if configs match.
// - Software reset does not depend on any reset pin level.
// - Resets abort embedded work and clear status; hard resets also abort reads.
// - Hard resets reload persistent lock from config bits 2:1; soft keeps it.
// - Hard resets reload dynamic access from config bit 4; soft keeps it.
// - Hard resets load password state from config bits 2 and 0; soft keeps it.
// - Boot register reloads on hard resets and is kept by software reset.
// - With select high stay active until program and erase work and any reset end.
`include "flash_reset_control_map.svh"
module flash_reset_control
	import flash_reset_control_pkg::*;
#(
	parameter int unsigned RECOVERY_CYCLES = (`RESET_RECOVERY_NS * `CLK_MHZ + 999) / 1000,
	parameter int unsigned SOFT_CYCLES = (`SOFT_RESET_NS * `CLK_MHZ + 999) / 1000
) (
	// System
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Serial link pins
	input wire logic link_sck,
	input wire logic select_n,
	input wire logic data_line_zero,
	// Device status
	output logic outputs_hiz,
	output logic active_power,
	output logic txn_accept,
	output logic txn_ignore,
	output logic [7:0] txn_opcode
);

	// Link domain: opcode shifter, cleared while select is high
	logic [2:0] bit_cnt;
	logic [6:0] shift_in;
	logic op_valid;
	logic [7:0] opcode_link;

	always_ff @(posedge link_sck or posedge select_n) begin
		if (select_n) begin
			bit_cnt <= 3'h0;
			shift_in <= 7'h00;
			op_valid <= 1'b0;
		end else begin
			bit_cnt <= bit_cnt + 3'h1;
			shift_in <= {shift_in[5:0], data_line_zero};
			if (bit_cnt == 3'h7)
				op_valid <= 1'b1;
		end
	end

	// Written once per transaction; stable long before the core samples it
	always_ff @(posedge link_sck) begin
		if (!select_n && !op_valid && bit_cnt == 3'h7)
			opcode_link <= {shift_in, data_line_zero};
	end

	// Core domain: three-stage pin synchronisers, change taken when stages two and three agree
	localparam int NSYNC = 4;
	wire [NSYNC-1:0] raw_in = {op_valid, link_sck, data_line_zero, select_n};
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	logic [NSYNC-1:0] sync3;
	logic [NSYNC-1:0] filt;

	always_ff @(posedge aclk) begin
		sync1 <= raw_in;
		sync2 <= sync1;
		sync3 <= sync2;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			filt <= 4'h1;
		else
			filt <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
	end

	wire sel_f = filt[0];
	wire dq_f = filt[1];
	wire sck_f = filt[2];
	wire opv_f = filt[3];

	logic sel_d;
	logic sck_d;
	logic sck_moved;
	logic dq_low;
	logic seen_op;
	logic [7:0] opcode;
	wire sel_rise = sel_f && !sel_d;
	wire sel_fall = !sel_f && sel_d;

	// Per-pulse observation of clock motion, data level and opcode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_d <= 1'b1;
			sck_d <= 1'b0;
			sck_moved <= 1'b0;
			dq_low <= 1'b0;
			seen_op <= 1'b0;
			opcode <= 8'h00;
		end else begin
			sel_d <= sel_f;
			sck_d <= sck_f;
			if (sel_fall)
				sck_moved <= 1'b0;
			else if (!sel_f && sck_f != sck_d)
				sck_moved <= 1'b1;
			if (!sel_f)
				dq_low <= dq_f;
			if (sel_fall)
				seen_op <= 1'b0;
			else if (!sel_f && opv_f && !seen_op) begin
				seen_op <= 1'b1;
				opcode <= opcode_link;
			end
		end
	end

	// Signalling reset pattern: clean pulses with alternating data line zero
	logic [2:0] sig_cnt;
	logic sig_prev;
	wire clean_pulse = sel_rise && !sck_moved;
	wire alt_ok = sig_cnt == 3'h0 || dq_low != sig_prev;
	wire [2:0] next_sig_cnt = !sel_rise ? sig_cnt :
		!clean_pulse ? 3'h0 :
		alt_ok ? sig_cnt + 3'h1 : 3'h1;
	wire sig_trigger = next_sig_cnt == `SIGNAL_PULSES;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sig_cnt <= 3'h0;
			sig_prev <= 1'b0;
		end else begin
			sig_cnt <= sig_trigger ? 3'h0 : next_sig_cnt;
			if (clean_pulse)
				sig_prev <= dq_low;
		end
	end

	// Register file
	logic [7:0] nv_config;
	logic [7:0] nv_boot;
	logic [4:0] prot_cfg;
	logic [7:0] vol_config;
	logic [7:0] boot_reg;
	logic ppb_lock;
	logic dyb_access;
	logic password_on;
	logic [7:0] status_bits;
	logic [2:0] ops;
	logic [7:0] hard_count;
	logic [7:0] soft_count;

	// Transaction decode at the end of each select pulse
	reset_state_t state;
	logic armed;
	logic hard_pending;
	logic [15:0] timer;
	wire cfg_match = vol_config == nv_config;
	wire is_status_read = seen_op &&
		(opcode == `CMD_READ_STATUS_ONE || opcode == `CMD_READ_ANY_REGISTER);
	wire txn_end = sel_rise && !sig_trigger;
	wire txn_refused = state == ST_RECOVERY ||
		(state == ST_SOFT_RESET && !(is_status_read && cfg_match));
	wire txn_taken = txn_end && !txn_refused;
	wire is_arm = seen_op && opcode == `CMD_SOFT_RESET_ARM;
	wire soft_start = txn_taken && armed && seen_op && opcode == `CMD_SOFT_RESET;
	wire hard_load = sig_trigger || hard_pending;
	wire soft_load = soft_start && !hard_load;
	wire timer_done = timer == 16'h0000;

	// Arm flag and reset sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed <= 1'b0;
			hard_pending <= 1'b1;
		end else begin
			hard_pending <= 1'b0;
			if (hard_load || soft_load)
				armed <= 1'b0;
			else if (txn_taken)
				armed <= is_arm;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_RECOVERY;
			timer <= 16'(RECOVERY_CYCLES - 1);
		end else if (hard_load) begin
			state <= ST_RECOVERY;
			timer <= 16'(RECOVERY_CYCLES - 1);
		end else if (soft_load) begin
			state <= ST_SOFT_RESET;
			timer <= 16'(SOFT_CYCLES - 1);
		end else if (state != ST_STANDBY) begin
			if (timer_done)
				state <= ST_STANDBY;
			else
				timer <= timer - 16'h0001;
		end
	end

	// AXI4-Lite slave: one write and one read at a time
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire do_write = !awready && !wready && !bvalid;
	wire [31:0] byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire wr_ops = do_write && aw_addr == `REG_OPS;
	wire wr_nv = do_write && aw_addr == `REG_NV_CFG;
	wire wr_vol = do_write && aw_addr == `REG_VOL_CFG;
	wire wr_prot = do_write && aw_addr == `REG_PROTECT;
	wire wr_known = wr_ops || wr_nv || wr_vol || wr_prot ||
		aw_addr == `REG_STATUS || aw_addr == `REG_COUNTS;

	wire [31:0] ops_word = {29'h0, ops};
	wire [31:0] nv_word = {11'h0, prot_cfg, nv_boot, nv_config};
	wire [31:0] vol_word = {16'h0, boot_reg, vol_config};
	wire [31:0] prot_word = {16'h0, status_bits, 5'h0, password_on, dyb_access, ppb_lock};
	wire [31:0] status_word = {26'h0, cfg_match, outputs_hiz, active_power, armed,
		state == ST_SOFT_RESET, state == ST_RECOVERY};
	wire [31:0] counts_word = {16'h0, soft_count, hard_count};
	wire [31:0] m_ops = (ops_word & ~byte_mask) | (w_data & byte_mask);
	wire [31:0] m_nv = (nv_word & ~byte_mask) | (w_data & byte_mask);
	wire [31:0] m_vol = (vol_word & ~byte_mask) | (w_data & byte_mask);
	wire [31:0] m_prot = (prot_word & ~byte_mask) | (w_data & byte_mask);

	wire rd_hit = araddr == `REG_STATUS || araddr == `REG_OPS || araddr == `REG_NV_CFG ||
		araddr == `REG_VOL_CFG || araddr == `REG_PROTECT || araddr == `REG_COUNTS;
	wire [31:0] rd_mux = araddr == `REG_STATUS ? status_word :
		araddr == `REG_OPS ? ops_word :
		araddr == `REG_NV_CFG ? nv_word :
		araddr == `REG_VOL_CFG ? vol_word :
		araddr == `REG_PROTECT ? prot_word :
		araddr == `REG_COUNTS ? counts_word : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				aw_addr <= {awaddr[7:2], 2'h0};
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Non-volatile image: only software and the bus reset change it; device resets leave it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nv_config <= `NV_CFG_RESET;
			nv_boot <= `NV_BOOT_RESET;
			prot_cfg <= `PCFG_RESET;
		end else if (wr_nv) begin
			nv_config <= m_nv[7:0];
			nv_boot <= m_nv[15:8];
			prot_cfg <= m_nv[20:16];
		end
	end

	// Volatile configuration and boot register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vol_config <= `NV_CFG_RESET;
			boot_reg <= `NV_BOOT_RESET;
		end else if (hard_load) begin
			vol_config <= nv_config;
			boot_reg <= nv_boot;
		end else if (soft_load) begin
			vol_config <= nv_config;
		end else if (wr_vol) begin
			vol_config <= m_vol[7:0];
			boot_reg <= m_vol[15:8];
		end
	end

	// Protection registers follow the configuration bits on hard resets only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ppb_lock <= 1'b0;
			dyb_access <= 1'b0;
			password_on <= 1'b0;
		end else if (hard_load) begin
			ppb_lock <= !(prot_cfg[`PCFG_PERSIST_HI_BIT] && prot_cfg[`PCFG_PERSIST_LO_BIT]);
			dyb_access <= prot_cfg[`PCFG_DYNAMIC_BIT];
			password_on <= !(prot_cfg[`PCFG_PERSIST_HI_BIT] && prot_cfg[`PCFG_PASSWORD_BIT]);
		end else if (wr_prot && !soft_load) begin
			ppb_lock <= m_prot[0];
			dyb_access <= m_prot[1];
			password_on <= m_prot[2];
		end
	end

	// Status bits and embedded operations; a reset beats a same-cycle write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_bits <= 8'h00;
			ops <= 3'h0;
		end else if (hard_load) begin
			status_bits <= 8'h00;
			ops <= 3'h0;
		end else if (soft_load) begin
			status_bits <= 8'h00;
			ops[`OP_PROGRAM_BIT] <= 1'b0;
			ops[`OP_ERASE_BIT] <= 1'b0;
		end else begin
			if (wr_prot)
				status_bits <= m_prot[15:8];
			if (wr_ops)
				ops <= m_ops[2:0];
		end
	end

	// Reset counters, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hard_count <= 8'h00;
			soft_count <= 8'h00;
		end else begin
			if (sig_trigger && hard_count != 8'hFF)
				hard_count <= hard_count + 8'h01;
			if (soft_load && soft_count != 8'hFF)
				soft_count <= soft_count + 8'h01;
		end
	end

	// Device outputs
	wire busy_work = ops[`OP_PROGRAM_BIT] || ops[`OP_ERASE_BIT];
	// A reset starting this cycle keeps power up before the state register follows
	wire next_active = !sel_f || busy_work || state != ST_STANDBY ||
		hard_load || soft_load;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			outputs_hiz <= 1'b1;
			active_power <= 1'b1;
			txn_accept <= 1'b0;
			txn_ignore <= 1'b0;
			txn_opcode <= 8'h00;
		end else begin
			outputs_hiz <= hard_load || (state == ST_RECOVERY && !timer_done);
			active_power <= next_active;
			txn_accept <= txn_taken;
			txn_ignore <= txn_end && txn_refused;
			if (txn_end)
				txn_opcode <= seen_op ? opcode : 8'h00;
		end
	end

endmodule : flash_reset_control

// >>> pkg/flash_reset_control_map.svh
// Offsets, field positions, reset values and timing counts of the flash reset control block
`ifndef FLASH_RESET_CONTROL_MAP_SVH
`define FLASH_RESET_CONTROL_MAP_SVH

// Register byte offsets
`define REG_STATUS 8'h00
`define REG_OPS 8'h04
`define REG_NV_CFG 8'h08
`define REG_VOL_CFG 8'h0C
`define REG_PROTECT 8'h10
`define REG_COUNTS 8'h14

// Status fields
`define ST_RECOVERY_BIT 0
`define ST_SOFT_BIT 1
`define ST_ARMED_BIT 2
`define ST_ACTIVE_BIT 3
`define ST_HIZ_BIT 4
`define ST_MATCH_BIT 5

// Embedded operation fields of the ops register
`define OP_PROGRAM_BIT 0
`define OP_ERASE_BIT 1
`define OP_READ_BIT 2

// Protection configuration fields
`define PCFG_PASSWORD_BIT 0
`define PCFG_PERSIST_LO_BIT 1
`define PCFG_PERSIST_HI_BIT 2
`define PCFG_DYNAMIC_BIT 4

// Reset values
`define NV_CFG_RESET 8'h00
`define NV_BOOT_RESET 8'h00
`define PCFG_RESET 5'h1F

// Opcodes on the x1 link
`define CMD_SOFT_RESET_ARM 8'h66
`define CMD_SOFT_RESET 8'h99
`define CMD_READ_STATUS_ONE 8'h05
`define CMD_READ_ANY_REGISTER 8'h65

// Timing
`define CLK_MHZ 200
`define RESET_RECOVERY_NS 35000
`define SOFT_RESET_NS 50000
`define SIGNAL_PULSES 3'h4

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> pkg/flash_reset_control_pkg.sv
// Types shared by the flash reset control block
package flash_reset_control_pkg;

	// Reset and power state of the device core
	typedef enum logic [1:0] {
		ST_STANDBY,
		ST_RECOVERY,
		ST_SOFT_RESET
	} reset_state_t;

endpackage : flash_reset_control_pkg

// >>> dv/flash_reset_control_sva.sv
// Concurrent checks on the ports of the flash reset control block
module flash_reset_control_sva #(
	parameter int unsigned RECOVERY_CYCLES = 7000,
	parameter int unsigned SOFT_CYCLES = 10000
) (
	// System
	input wire logic aclk,
	input wire logic aresetn,
	// Link and status
	input wire logic select_n,
	input wire logic outputs_hiz,
	input wire logic active_power,
	input wire logic txn_accept,
	input wire logic txn_ignore
);
	timeunit 1ns;
	timeprecision 100ps;

	int unsigned hiz_cnt;

	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Length of the current float window
	always_ff @(posedge aclk) begin
		if (!aresetn || !outputs_hiz) begin
			hiz_cnt <= 0;
		end else begin
			hiz_cnt <= hiz_cnt + 1;
		end
	end

	a_hiz_quiet: assert property (outputs_hiz |-> !txn_accept)
		else $error("Transaction taken while floating");
	a_hiz_power: assert property (outputs_hiz |-> active_power)
		else $error("Standby during recovery");
	a_select_power: assert property (!select_n [*8] |-> active_power)
		else $error("Standby while selected");
	a_hiz_min: assert property ($fell(outputs_hiz) |-> hiz_cnt >= RECOVERY_CYCLES - 1)
		else $error("Recovery too short");
	a_hiz_max: assert property (outputs_hiz |-> hiz_cnt <= RECOVERY_CYCLES + 4)
		else $error("Recovery too long");
	a_reset_at_end: assert property ($rose(outputs_hiz) |-> select_n && $past(select_n, 4))
		else $error("Reset before select returned high");
	a_end_pulse: assert property ((txn_accept || txn_ignore) |-> $past(select_n, 4))
		else $error("Transaction end without select high");
	a_pulse_once: assert property ((txn_accept || txn_ignore) |=> !(txn_accept || txn_ignore))
		else $error("End pulse longer than one cycle");
endmodule : flash_reset_control_sva

bind flash_reset_control flash_reset_control_sva #(
	.RECOVERY_CYCLES(RECOVERY_CYCLES),
	.SOFT_CYCLES(SOFT_CYCLES)
) checker_inst (
	.aclk(aclk),
	.aresetn(aresetn),
	.select_n(select_n),
	.outputs_hiz(outputs_hiz),
	.active_power(active_power),
	.txn_accept(txn_accept),
	.txn_ignore(txn_ignore)
);

// >>> dv/flash_host.sv
// Host controller model on the x1 link: select, clock and data line zero
module flash_host (
	// Link pins
	output logic link_sck,
	output logic select_n,
	output logic data_line_zero
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		link_sck = 1'h0;
		select_n = 1'h0;
		data_line_zero = 1'h1;
		// A real rising edge clears the link-side counters at start-up
		#1 select_n = 1'h1;
	end

	// Opcode MSB first on rising clock; clock idles low outside frames
	task automatic xfer(input logic [7:0] op);
		#37 select_n = 1'h0;
		for (int i = 7; i >= 0; i--) begin
			data_line_zero = op[i];
			#62.5 link_sck = 1'h1;
			#62.5 link_sck = 1'h0;
		end
		#62.5 select_n = 1'h1;
		data_line_zero = ~data_line_zero; // Released line must not hold its level
		#100;
	endtask : xfer

	// Select pulses with the clock still, data line zero alternating
	task automatic sig_reset(input int n);
		for (int i = 0; i < n; i++) begin
			#43 select_n = 1'h0;
			data_line_zero = i[0];
			#100 select_n = 1'h1;
			data_line_zero = ~data_line_zero;
		end
		#100;
	endtask : sig_reset
endmodule : flash_host

// >>> dv/tb_top.sv
// Self-checking bench of the flash reset control block
`include "flash_reset_control_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int RC = 40;
	localparam int SC = 2000;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, hiz, act, acc_p, ign_p, sck, sel_n, dq0;
	logic [1:0] bresp, rresp, br, rr;
	logic [31:0] rdata, d, c;
	logic [7:0] opc;
	int seed = 4765;
	int num_errors = 0;
	int compares = 0;
	int acc = 0;
	int ign = 0;
	int a0, i0;

	flash_reset_control #(.RECOVERY_CYCLES(RC), .SOFT_CYCLES(SC)) dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .link_sck(sck), .select_n(sel_n), .data_line_zero(dq0),
		.outputs_hiz(hiz), .active_power(act), .txn_accept(acc_p), .txn_ignore(ign_p),
		.txn_opcode(opc));
	flash_host host (.link_sck(sck), .select_n(sel_n), .data_line_zero(dq0));

	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		acc <= acc + int'(acc_p === 1'h1);
		ign <= ign + int'(ign_p === 1'h1);
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ad, wd;
		ad = 1'h0;
		wd = 1'h0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			ad = ad | awready;
			wd = wd | wready;
			awvalid <= !ad;
			wvalid <= !wd;
		end
		while (bvalid !== 1'h1) @(posedge aclk);
		br = bresp;
		bready <= 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		while (rvalid !== 1'h1) @(posedge aclk);
		d = rdata;
		rr = rresp;
		rready <= 1'h0;
	endtask : rd

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(d & m, e);
	endtask : rchk

	task automatic conclude();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		while (hiz !== 1'h0) @(posedge aclk);
		rchk(8'h10, 32'h7, 32'h2);
		rd(8'h18);
		chk(d, 32'h0);
		chk(rr, `RESP_SLVERR);
		wr(8'h1C, 32'hFFFF_FFFF);
		chk(br, `RESP_SLVERR);
		wr(8'h00, 32'hFFFF_FFFF);
		rchk(8'h00, 32'h3F, 32'h20);
		wr(8'h04, 32'h1);
		repeat (4) @(posedge aclk);
		chk(act, 1'h1);
		wr(8'h04, 32'h0);
		repeat (4) @(posedge aclk);
		chk(act, 1'h0);
		for (int k = 0; k < 2; k++) begin
			c = $random(seed);
			wr(8'h08, c & 32'h1F_FFFF);
			wr(8'h0C, {16'h0, ~c[15:8], c[7:0] ^ {8{k == 0}}});
			wr(8'h10, {29'h0, ~c[18:16]});
			wr(8'h04, 32'h3);
			if (k == 0) begin
				host.xfer(`CMD_SOFT_RESET_ARM);
				host.xfer(`CMD_READ_STATUS_ONE);
				host.xfer(`CMD_SOFT_RESET);
				rchk(8'h00, 32'h6, 32'h0);
			end
			host.xfer(`CMD_SOFT_RESET_ARM);
			rchk(8'h00, 32'h4, 32'h4);
			host.xfer(`CMD_SOFT_RESET);
			a0 = acc;
			i0 = ign;
			if (k == 0) begin
				wr(8'h0C, {16'h0, ~c[15:8], ~c[7:0]});
				host.xfer(`CMD_READ_STATUS_ONE);
				chk(acc - a0, 0);
				chk(ign - i0, 1);
				wr(8'h0C, {16'h0, ~c[15:8], c[7:0]});
			end else begin
				host.xfer(`CMD_READ_STATUS_ONE);
				host.xfer(`CMD_READ_ANY_REGISTER);
				host.xfer(`CMD_SOFT_RESET_ARM);
				chk(acc - a0, 2);
				chk(ign - i0, 1);
			end
			do rd(8'h00); while (d[1] === 1'h1);
			rchk(8'h00, 32'h4, 32'h0);
			rchk(8'h0C, 32'hFFFF, {16'h0, ~c[15:8], c[7:0]});
			rchk(8'h10, 32'h7, {29'h0, ~c[18:16]});
			rchk(8'h04, 32'h3, 32'h0);
			rchk(8'h14, 32'hFF00, (k + 1) << 8);
		end
		for (int j = 0; j < 2; j++) begin
			c = $random(seed);
			wr(8'h08, c & 32'h1F_FFFF);
			wr(8'h0C, ~c & 32'hFFFF);
			wr(8'h10, {29'h0, c[23:21]});
			wr(8'h04, 32'h7);
			host.sig_reset(3);
			host.xfer(`CMD_READ_STATUS_ONE);
			chk(opc, `CMD_READ_STATUS_ONE);
			chk(hiz, 1'h0);
			host.sig_reset(4);
			chk(hiz, 1'h1);
			while (hiz !== 1'h0) @(posedge aclk);
			rchk(8'h10, 32'h7, {29'h0, ~(c[18] & c[16]), c[20], ~(c[18] & c[17])});
			rchk(8'h0C, 32'hFFFF, c & 32'hFFFF);
			rchk(8'h04, 32'h7, 32'h0);
			rchk(8'h14, 32'hFF, j + 1);
		end
		conclude();
	end

	initial begin
		#200000;
		num_errors++;
		conclude();
	end
endmodule : tb_top
